// [rtl/gss_pkg.sv]
// Package for the general-output strobe assignment block.
// Assumes one 25 MHz clock domain and a plain strobe register port.
package gss_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] GSS_ADDR_SELECT  = 8'h26;
   localparam logic [7:0] GSS_ADDR_CONTROL = 8'h27;
   localparam logic [7:0] GSS_ADDR_STATUS  = 8'h28;
   localparam logic [7:0] GSS_SELECT_RESET = 8'h35;

   // ==========================================================
   // Field layout
   localparam int GSS_THREE_LSB = 4;
   localparam int GSS_ONE_LSB   = 0;
   localparam int GSS_SEL_W     = 4;

   // ==========================================================
   // Strobe range
   localparam logic [3:0] GSS_STROBE_FIRST = 4'h3;
   localparam logic [3:0] GSS_STROBE_LAST  = 4'ha;

   // ==========================================================
   // Strobe step timing
   localparam int GSS_CLK_MHZ      = 25;
   localparam int GSS_STEP_US      = 1;
   localparam int GSS_STEP_CYCLES  = GSS_STEP_US * GSS_CLK_MHZ;

   typedef enum logic [1:0] {
      GSS_IDLE,
      GSS_RUN,
      GSS_DONE
   } gss_state_type;

endpackage : gss_pkg

// [rtl/gss_strobe_match.sv]
// Decodes one strobe selector against the current sequencer strobe.
// Assumes the strobe number is valid only while the sequencer runs.
`timescale 1ns/1ps
module gss_strobe_match
   import gss_pkg::*;
#(
   parameter int SEL_W = GSS_SEL_W
)
(
   // Selector and strobe
   input  wire logic [SEL_W-1:0] sel,
   input  wire logic [3:0]       strobe_num,
   input  wire logic             strobe_fire,
   // Result
   output logic                  in_control,
   output logic                  hit
);

   always_comb
   begin
      // Codes below three and above ten leave the output alone
      in_control = (sel >= GSS_STROBE_FIRST) && (sel <= GSS_STROBE_LAST);
      hit        = in_control && strobe_fire && (sel == strobe_num);
   end

endmodule : gss_strobe_match

// [rtl/gss_top.sv]
// General-output strobe assignment with a small power-up strobe walker.
// Assumes synchronous inputs on ref_clk and single-cycle register strobes.
//
// Operation
// - Select register at 0x26, eight bits, resets to 0x35.
// - Bits 7-4 select strobe for output three, default three.
// - Bits 3-0 select strobe for output one, default five.
// - Selector codes 0-2 leave output outside sequencer control.
// - Codes 3 to 10 turn output on at that strobe number.
// - Codes 11 to 15 leave output outside sequencer control.
`timescale 1ns/1ps
module gss_top
   import gss_pkg::*;
#(
   parameter int STEP_CYCLES = GSS_STEP_CYCLES
)
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   // Factory seal status, meaningless with backup converters off
   input  wire logic       factory_seal_flag,
   // Sequencer outputs
   output logic            general_output_three,
   output logic            general_output_one,
   output logic            seq_busy
);
   import gss_pkg::*;

   typedef struct packed {
      logic [7:0]    select;
      gss_state_type state;
      logic [3:0]    strobe;
      logic [15:0]   count;
      logic          out_three;
      logic          out_one;
      logic [7:0]    rdata;
      logic          busy;
   } gss_regs_type;

   gss_regs_type cur_reg;
   gss_regs_type cur_next;

   logic three_ctl;
   logic three_hit;
   logic one_ctl;
   logic one_hit;
   logic fire;

   // ==========================================================
   // Strobe decode
   assign fire = (cur_reg.state == GSS_RUN) && (cur_reg.count == 16'h0000);

   gss_strobe_match u_match_three (
      .sel         (cur_reg.select[GSS_THREE_LSB +: GSS_SEL_W]),
      .strobe_num  (cur_reg.strobe),
      .strobe_fire (fire),
      .in_control  (three_ctl),
      .hit         (three_hit)
   );

   gss_strobe_match u_match_one (
      .sel         (cur_reg.select[GSS_ONE_LSB +: GSS_SEL_W]),
      .strobe_num  (cur_reg.strobe),
      .strobe_fire (fire),
      .in_control  (one_ctl),
      .hit         (one_hit)
   );

   // ==========================================================
   // Next state
   always_comb
   begin
      cur_next       = cur_reg;
      cur_next.rdata = 8'h00;
      if (reg_wr && reg_addr == GSS_ADDR_SELECT)
      begin
         cur_next.select = reg_wdata;
      end
      if (reg_rd)
      begin
         case (reg_addr)
            GSS_ADDR_SELECT:  cur_next.rdata = cur_reg.select;
            GSS_ADDR_CONTROL: cur_next.rdata = 8'h00;
            // Seal flag is passed through raw; software must discard it
            // when the backup converters are off
            GSS_ADDR_STATUS:  cur_next.rdata = {4'h0, factory_seal_flag,
                                                cur_reg.out_three, cur_reg.out_one,
                                                cur_reg.state == GSS_RUN};
            default:          cur_next.rdata = 8'h00;
         endcase
      end
      case (cur_reg.state)
         GSS_IDLE:
         begin
            cur_next.count = 16'h0000;
         end
         GSS_RUN:
         begin
            if (cur_reg.count != 16'h0000)
            begin
               cur_next.count = cur_reg.count - 16'h0001;
            end
            else
            begin
               if (three_hit)
               begin
                  cur_next.out_three = 1'b1;
               end
               if (one_hit)
               begin
                  cur_next.out_one = 1'b1;
               end
               if (cur_reg.strobe == GSS_STROBE_LAST)
               begin
                  cur_next.state = GSS_DONE;
               end
               else
               begin
                  cur_next.strobe = cur_reg.strobe + 4'h1;
                  cur_next.count  = 16'(STEP_CYCLES - 1);
               end
            end
         end
         GSS_DONE:
         begin
            cur_next.count = 16'h0000;
         end
         default:
         begin
            cur_next.state = GSS_IDLE;
         end
      endcase
      // Writing bit 0 of the control register starts a power-up run unless one is already running.
      // Placed after the state case so the idle count clear cannot
      // shorten the first strobe interval.
      if (reg_wr && reg_addr == GSS_ADDR_CONTROL && reg_wdata[0] && cur_reg.state != GSS_RUN)
      begin
         cur_next.state     = GSS_RUN;
         cur_next.strobe    = GSS_STROBE_FIRST;
         cur_next.count     = 16'(STEP_CYCLES - 1);
         // Outputs handed to the sequencer start off; others keep level
         cur_next.out_three = three_ctl ? 1'b0 : cur_reg.out_three;
         cur_next.out_one   = one_ctl ? 1'b0 : cur_reg.out_one;
      end
      // Busy is registered so the pin comes straight from a flop
      cur_next.busy = (cur_next.state == GSS_RUN);
   end

   // ==========================================================
   // State register
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur_reg           <= '0;
         cur_reg.select    <= GSS_SELECT_RESET;
         cur_reg.state     <= GSS_IDLE;
         cur_reg.strobe    <= GSS_STROBE_FIRST;
      end
      else
      begin
         cur_reg <= cur_next;
      end
   end

   assign reg_rdata            = cur_reg.rdata;
   assign general_output_three = cur_reg.out_three;
   assign general_output_one   = cur_reg.out_one;
   assign seq_busy             = cur_reg.busy;

   // ==========================================================
   // Checks
   property p_reset_value;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(rst_n) |-> cur_reg.select == GSS_SELECT_RESET;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("select reset wrong");

   property p_write_select;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == GSS_ADDR_SELECT) |=> cur_reg.select == $past(reg_wdata);
   endproperty
   a_write_select: assert property (p_write_select) else $error("select not written");

   property p_read_select;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == GSS_ADDR_SELECT && !reg_wr) |=> reg_rdata == $past(cur_reg.select);
   endproperty
   a_read_select: assert property (p_read_select) else $error("select readback wrong");

   property p_low_code_off;
      @(posedge ref_clk) disable iff (!rst_n)
      (seq_busy && cur_reg.select[3:0] < GSS_STROBE_FIRST && !general_output_one)
         |=> !general_output_one;
   endproperty
   a_low_code_off: assert property (p_low_code_off) else $error("low code drove output");

   property p_high_code_off;
      @(posedge ref_clk) disable iff (!rst_n)
      (seq_busy && cur_reg.select[7:4] > GSS_STROBE_LAST && !general_output_three)
         |=> !general_output_three;
   endproperty
   a_high_code_off: assert property (p_high_code_off) else $error("high code drove output");

   property p_hit_sets;
      @(posedge ref_clk) disable iff (!rst_n)
      (fire && cur_reg.strobe == cur_reg.select[3:0]) |=> general_output_one;
   endproperty
   a_hit_sets: assert property (p_hit_sets) else $error("output one missed strobe");

   property p_ascending;
      @(posedge ref_clk) disable iff (!rst_n)
      (fire && cur_reg.strobe != GSS_STROBE_LAST) |=> cur_reg.strobe == $past(cur_reg.strobe) + 4'h1;
   endproperty
   a_ascending: assert property (p_ascending) else $error("strobe order broken");

   property p_no_early;
      @(posedge ref_clk) disable iff (!rst_n)
      (seq_busy && !fire && !general_output_three) |=> !general_output_three;
   endproperty
   a_no_early: assert property (p_no_early) else $error("output three rose between strobes");

endmodule : gss_top

// [dv/gss_testbench.sv]
// Self-checking bench for gss_top: register port, selector decode and strobe walk.
// Assumes the rtl/ package and modules are compiled first; STEP_CYCLES shortened.
`timescale 1ns/1ps
module testbench;
   import gss_pkg::*;
   localparam int STEP = 2;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic        factory_seal_flag = 1'b0;
   logic        general_output_three;
   logic        general_output_one;
   logic        seq_busy;
   int          num_errors = 0;
   int          num_checks = 0;
   int          cycles = 0;
   logic [31:0] lfsr_reg = 32'hdc958729;
   logic [7:0]  rd_val;
   logic [7:0]  corner [6] = '{8'h00, 8'h2a, 8'hab, 8'hf3, 8'h33, 8'hb2};

   always #20 ref_clk = ~ref_clk;

   gss_top #(.STEP_CYCLES(STEP)) dut (
      .ref_clk              (ref_clk),
      .rst_n                (rst_n),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_wr               (reg_wr),
      .reg_rd               (reg_rd),
      .reg_rdata            (reg_rdata),
      .factory_seal_flag    (factory_seal_flag),
      .general_output_three (general_output_three),
      .general_output_one   (general_output_one),
      .seq_busy             (seq_busy)
   );

   // ==========================================================
   // Helpers
   function automatic logic [31:0] lfsr_step(input logic [31:0] v);
      return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
   endfunction : lfsr_step

   // Cycle of first turn-on after the start write; 0 means never
   function automatic logic [7:0] exp_on(input logic [3:0] s);
      if (s >= GSS_STROBE_FIRST && s <= GSS_STROBE_LAST)
      begin
         return 8'((int'(s) - 2) * STEP);
      end
      return 8'h00;
   endfunction : exp_on

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] expd);
      num_checks++;
      if (seen !== expd)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, expd, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge ref_clk);
   endtask : rd

   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   // Uncontrolled outputs never turn off, so every walk starts from a fresh reset
   task automatic walk(input logic [7:0] sel, input bit do_write);
      logic [7:0] first1;
      logic [7:0] first3;
      first1 = 8'h00;
      first3 = 8'h00;
      rst_n <= 1'b0;
      @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      if (do_write)
         wr(GSS_ADDR_SELECT, sel);
      rd(GSS_ADDR_SELECT, rd_val);
      check("select", rd_val, sel);
      check("outs_idle", {6'h0, general_output_three, general_output_one}, 8'h00);
      wr(GSS_ADDR_CONTROL, 8'h01);
      for (int n = 1; n <= 40; n++)
      begin
         @(posedge ref_clk);
         #1;
         if (n == 1)
            check("busy_run", {7'h0, seq_busy}, 8'h01);
         if (general_output_one === 1'b1 && first1 == 8'h00)
            first1 = 8'(n);
         if (general_output_three === 1'b1 && first3 == 8'h00)
            first3 = 8'(n);
      end
      check("out_one_on", first1, exp_on(sel[3:0]));
      check("out_three_on", first3, exp_on(sel[7:4]));
      check("busy_end", {7'h0, seq_busy}, 8'h00);
      rd(GSS_ADDR_STATUS, rd_val);
      check("status_outs", {5'h0, rd_val[2:0]},
            {5'h0, exp_on(sel[7:4]) != 8'h00, exp_on(sel[3:0]) != 8'h00, 1'b0});
      @(posedge ref_clk);
   endtask : walk

   // ==========================================================
   // Timeout and main sequence
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         num_errors++;
         print_verdict();
      end
   end

   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rd(GSS_ADDR_SELECT, rd_val);
      check("select_reset", rd_val, GSS_SELECT_RESET);
      rd(8'h30, rd_val);
      check("unmapped_rd", rd_val, 8'h00);
      wr(8'h31, 8'hff);
      rd(GSS_ADDR_SELECT, rd_val);
      check("unmapped_wr", rd_val, GSS_SELECT_RESET);
      rd(GSS_ADDR_CONTROL, rd_val);
      check("control_rd", rd_val, 8'h00);
      // Seal bit is only trusted here because backup converters are modelled on
      factory_seal_flag <= 1'b1;
      @(posedge ref_clk);
      rd(GSS_ADDR_STATUS, rd_val);
      check("status_seal", {4'h0, rd_val[3], 3'h0}, 8'h08);
      walk(GSS_SELECT_RESET, 1'b0);
      foreach (corner[i])
         walk(corner[i], 1'b1);
      for (int k = 0; k < 10; k++)
      begin
         lfsr_reg = lfsr_step(lfsr_reg);
         walk(lfsr_reg[7:0], 1'b1);
      end
      print_verdict();
   end
endmodule : testbench
